/* File: rtl/off_timing_status.sv */
// Turn-off delay and fall time per output, commit of fall time, and the
// global fault summary byte and word, reached by command code.
// Assumes a serial front end on lclk_i and asynchronous status pins.
`timescale 1ns/1ps
`include "off_timing_cfg.svh"
module off_timing_status #(
   parameter int CYC_PER_US = `NS_PER_US / `TCLK_NS
) (
   // Core clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Link clock and request
   input wire logic lclk_i,
   input wire logic lreq_i,
   input wire logic lwr_i,
   input wire logic lpage_i,
   input wire logic [7:0] lcode_i,
   input off_timing_pkg::word_t ldata_i,
   // Answer on the link clock
   output logic lbusy_o,
   output logic lrsp_valid_o,
   output logic lrsp_err_o,
   output off_timing_pkg::word_t lrsp_data_o,
   // Per-output pins
   input wire logic [1:0] en_i,
   input wire logic [1:0] pgood_i,
   input wire logic [1:0] vout_ov_i,
   input wire logic [1:0] vout_oth_i,
   input wire logic [1:0] iout_oc_i,
   input wire logic [1:0] iout_oth_i,
   // Global status pins
   input wire logic vin_uv_i,
   input wire logic vin_oth_i,
   input wire logic temp_i,
   input wire logic comm_mem_logic_fault_flag_i,
   input wire logic vendor_event_flag_i,
   input wire logic other_i,
   // Sequencer view per output
   output logic [1:0] pwr_on_o,
   output logic [1:0] fall_act_o
);
   import off_timing_pkg::*;
   localparam int NPAGE = 2;
   localparam word_t DLY_MAX = 16'(`OFF_DELAY_MAX_US / `OFF_DELAY_UNIT_US);
   localparam word_t FALL_MAX = 16'(`OFF_FALL_MAX_US);

   off_cmd_if cmd ();

   off_link u_link (
      .lclk_i(lclk_i),
      .rst_b_i(rst_b_i),
      .lreq_i(lreq_i),
      .lwr_i(lwr_i),
      .lpage_i(lpage_i),
      .lcode_i(lcode_i),
      .ldata_i(ldata_i),
      .lbusy_o(lbusy_o),
      .lrsp_valid_o(lrsp_valid_o),
      .lrsp_err_o(lrsp_err_o),
      .lrsp_data_o(lrsp_data_o),
      .cmd(cmd)
   );

   // Pin synchronisers; only the second stage feeds logic
   logic [17:0] pin_raw, pin_s1_r, pin_s2_r;
   assign pin_raw = {en_i, pgood_i, vout_ov_i, vout_oth_i, iout_oc_i,
                     iout_oth_i, vin_uv_i, vin_oth_i, temp_i,
                     comm_mem_logic_fault_flag_i, vendor_event_flag_i,
                     other_i};
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pin_s1_r <= 18'h00000;
         pin_s2_r <= 18'h00000;
      end else begin
         pin_s1_r <= pin_raw;
         pin_s2_r <= pin_s1_r;
      end
   end
   logic [1:0] en_s, pg_s, vov_s, voth_s, ioc_s, ioth_s;
   logic vuv_s, vinoth_s, temp_s, cml_s, vend_s, oth_s;
   assign {en_s, pg_s, vov_s, voth_s, ioc_s, ioth_s, vuv_s, vinoth_s,
           temp_s, cml_s, vend_s, oth_s} = pin_s2_r;

   // Request crossing from the link clock
   logic req_s1_r, req_s2_r, req_s3_r;
   logic req_edge;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         req_s1_r <= 1'b0;
         req_s2_r <= 1'b0;
         req_s3_r <= 1'b0;
      end else begin
         req_s1_r <= cmd.req_tgl;
         req_s2_r <= req_s1_r;
         req_s3_r <= req_s2_r;
      end
   end
   assign req_edge = req_s2_r ^ req_s3_r;

   word_t delay_r [NPAGE];
   word_t fall_pend_r [NPAGE];
   word_t fall_act_r [NPAGE];
   word_t sum_r;
   logic do_wr, do_commit, bad;
   word_t rd_val;

   // Decode of one request
   always_comb begin
      do_wr = 1'b0;
      do_commit = 1'b0;
      bad = 1'b0;
      rd_val = 16'h0000;
      unique case (cmd.code)
         `REG_OFF_DELAY: begin
            rd_val = delay_r[cmd.page];
            bad = cmd.wr && cmd.wdata > DLY_MAX;
            do_wr = cmd.wr && !bad;
         end
         `REG_OFF_FALL: begin
            rd_val = fall_pend_r[cmd.page];
            bad = cmd.wr && cmd.wdata > FALL_MAX;
            do_wr = cmd.wr && !bad;
         end
         `REG_SUM_BYTE: begin
            rd_val = {8'h00, sum_r[7:0]};
            bad = cmd.wr;
         end
         `REG_SUM_WORD: begin
            rd_val = sum_r;
            bad = cmd.wr;
         end
         `CMD_COMMIT: begin
            do_commit = cmd.wr;
            bad = !cmd.wr;
         end
         default: bad = 1'b1;
      endcase
   end

   // Settings, one copy per page
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int p = 0; p < NPAGE; p++) begin
            delay_r[p] <= `OFF_DELAY_RST;
            fall_pend_r[p] <= `OFF_FALL_RST;
         end
      end else if (req_edge && do_wr) begin
         if (cmd.code == `REG_OFF_DELAY) delay_r[cmd.page] <= cmd.wdata;
         else fall_pend_r[cmd.page] <= cmd.wdata;
      end
   end

   // Fall time in use changes only on commit, for both pages
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int p = 0; p < NPAGE; p++) fall_act_r[p] <= `OFF_FALL_RST;
      end else if (req_edge && do_commit) begin
         for (int p = 0; p < NPAGE; p++)
            fall_act_r[p] <= fall_pend_r[p];
      end
   end

   // Answer; word set with the toggle so it is stable when seen
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cmd.ack_tgl <= 1'b0;
         cmd.err <= 1'b0;
         cmd.rdata <= 16'h0000;
      end else if (req_edge) begin
         cmd.ack_tgl <= ~cmd.ack_tgl;
         cmd.err <= bad;
         cmd.rdata <= cmd.wr ? 16'h0000 : rd_val;
      end
   end

   // Sequencers
   seq_state_e st [NPAGE];
   logic [1:0] off_pg;
   for (genvar g = 0; g < NPAGE; g++) begin : g_page
      off_seq #(.CYC_PER_US(CYC_PER_US)) u_seq (
         .clk_i(clk_i),
         .rst_b_i(rst_b_i),
         .en_i(en_s[g]),
         .delay_i(delay_r[g]),
         .fall_i(fall_act_r[g]),
         .state_o(st[g])
      );
      assign off_pg[g] = (st[g] == SEQ_OFF);
      always_ff @(posedge clk_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            pwr_on_o[g] <= 1'b0;
            fall_act_o[g] <= 1'b0;
         end else begin
            pwr_on_o[g] <= !off_pg[g];
            fall_act_o[g] <= (st[g] == SEQ_FALL);
         end
      end
   end

   // Summary, refreshed every cycle from live status
   word_t sum_nxt;
   always_comb begin
      sum_nxt = 16'h0000;
      sum_nxt[`SB_OFF] = |off_pg;
      sum_nxt[`SB_VOUT_OV] = |vov_s;
      sum_nxt[`SB_IOUT_OC] = |ioc_s;
      sum_nxt[`SB_VIN_UV] = vuv_s;
      sum_nxt[`SB_TEMP] = temp_s;
      sum_nxt[`SB_CML] = cml_s;
      sum_nxt[`SB_OTHER] = oth_s;
      sum_nxt[`SW_VOUT] = |(vov_s | voth_s);
      sum_nxt[`SW_IOUT] = |(ioc_s | ioth_s);
      sum_nxt[`SW_INPUT] = vuv_s | vinoth_s;
      sum_nxt[`SW_VENDOR] = vend_s;
      sum_nxt[`SW_PG_BAD] = |(~pg_s);
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) sum_r <= 16'h0000;
      else sum_r <= sum_nxt;
   end

   // Checking aid: first cycle after reset has no history
   logic live_r;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) live_r <= 1'b0;
      else live_r <= 1'b1;
   end

   sequence s_req_seen;
      req_edge;
   endsequence
   property p_ack;
      @(posedge clk_i) disable iff (!rst_b_i)
      s_req_seen |=> cmd.ack_tgl != $past(cmd.ack_tgl);
   endproperty
   a_ack: assert property (p_ack)
      else $error("request not answered next cycle");
   property p_page_sep;
      @(posedge clk_i) disable iff (!rst_b_i)
      (req_edge && do_wr && cmd.page == 1'b0) |=> $stable(delay_r[1])
         && $stable(fall_pend_r[1]);
   endproperty
   a_page_sep: assert property (p_page_sep)
      else $error("write to page 0 disturbed page 1");
   property p_dly_max;
      @(posedge clk_i) disable iff (!rst_b_i)
      delay_r[0] <= DLY_MAX && delay_r[1] <= DLY_MAX;
   endproperty
   a_dly_max: assert property (p_dly_max)
      else $error("delay setting beyond range");
   property p_commit;
      @(posedge clk_i) disable iff (!rst_b_i)
      live_r && (fall_act_r[0] != $past(fall_act_r[0]))
         |-> $past(req_edge && do_commit);
   endproperty
   a_commit: assert property (p_commit)
      else $error("fall time applied without commit");
   property p_byte_rd;
      @(posedge clk_i) disable iff (!rst_b_i)
      (req_edge && !cmd.wr && cmd.code == `REG_SUM_BYTE)
         |=> cmd.rdata == {8'h00, $past(sum_r[7:0])} && !cmd.err;
   endproperty
   a_byte_rd: assert property (p_byte_rd)
      else $error("summary byte read wrong");
   property p_off;
      @(posedge clk_i) disable iff (!rst_b_i)
      live_r |-> sum_r[`SB_OFF] == $past(|off_pg);
   endproperty
   a_off: assert property (p_off)
      else $error("off bit does not follow outputs");
   property p_or;
      @(posedge clk_i) disable iff (!rst_b_i)
      live_r |-> sum_r[`SW_VOUT] == $past(|(vov_s | voth_s))
         && sum_r[`SB_VOUT_OV] == $past(|vov_s);
   endproperty
   a_or: assert property (p_or)
      else $error("voltage summary is not OR of outputs");
   property p_pg;
      @(posedge clk_i) disable iff (!rst_b_i)
      live_r |-> sum_r[`SW_PG_BAD] == $past(!(&pg_s));
   endproperty
   a_pg: assert property (p_pg)
      else $error("power good summary wrong");
   property p_zero;
      @(posedge clk_i) disable iff (!rst_b_i)
      (sum_r & ~`SUM_USED_MASK) == 16'h0000;
   endproperty
   a_zero: assert property (p_zero)
      else $error("unused summary bit set");
endmodule

/* File: rtl/off_timing_cfg.svh */
// Command codes, field positions, reset values and timing for the
// turn-off timing and status summary block.
// Assumes inclusion by bare name from the design files.
`ifndef OFF_TIMING_CFG_SVH
`define OFF_TIMING_CFG_SVH
`define REG_OFF_DELAY 8'h64
`define REG_OFF_FALL 8'h65
`define REG_SUM_BYTE 8'h78
`define REG_SUM_WORD 8'h79
`define CMD_COMMIT 8'hE7
`define OFF_DELAY_RST 16'h0000
`define OFF_FALL_RST 16'h01F4
`define OFF_DELAY_UNIT_US 10
`define OFF_DELAY_MAX_US 10000
`define OFF_FALL_MAX_US 10000
`define TCLK_NS 25
`define NS_PER_US 1000
`define SB_OFF 6
`define SB_VOUT_OV 5
`define SB_IOUT_OC 4
`define SB_VIN_UV 3
`define SB_TEMP 2
`define SB_CML 1
`define SB_OTHER 0
`define SW_VOUT 15
`define SW_IOUT 14
`define SW_INPUT 13
`define SW_VENDOR 12
`define SW_PG_BAD 11
`define SUM_USED_MASK 16'hF87F
`endif

/* File: rtl/off_timing_pkg.sv */
// Types shared by the turn-off timing and status summary block.
// Assumes nothing of its surroundings.
package off_timing_pkg;
   typedef logic [15:0] word_t;
   typedef enum logic [3:0] {
      SEQ_OFF  = 4'b0001,
      SEQ_ON   = 4'b0010,
      SEQ_DLY  = 4'b0100,
      SEQ_FALL = 4'b1000
   } seq_state_e;
endpackage

/* File: rtl/off_cmd_if.sv */
// Request and answer path between the link port and the register core.
// Assumes the link side holds its fields while a request is open.
`timescale 1ns/1ps
interface off_cmd_if;
   logic req_tgl;
   logic wr;
   logic page;
   logic [7:0] code;
   logic [15:0] wdata;
   logic ack_tgl;
   logic err;
   logic [15:0] rdata;
   modport link (output req_tgl, wr, page, code, wdata,
                 input ack_tgl, err, rdata);
   modport core (input req_tgl, wr, page, code, wdata,
                 output ack_tgl, err, rdata);
endinterface

/* File: rtl/off_link.sv */
// Link clock side of the command path: takes one request, waits for the
// core answer through a toggle crossing. Assumes lclk_i runs until answer.
`timescale 1ns/1ps
module off_link (
   // Link clock and reset
   input wire logic lclk_i,
   input wire logic rst_b_i,
   // Request from the serial front end
   input wire logic lreq_i,
   input wire logic lwr_i,
   input wire logic lpage_i,
   input wire logic [7:0] lcode_i,
   input off_timing_pkg::word_t ldata_i,
   // Answer
   output logic lbusy_o,
   output logic lrsp_valid_o,
   output logic lrsp_err_o,
   output off_timing_pkg::word_t lrsp_data_o,
   // Core side
   off_cmd_if.link cmd
);
   import off_timing_pkg::*;
   logic ack_s1_r, ack_s2_r, ack_s3_r;
   logic ack_seen;

   always_ff @(posedge lclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ack_s1_r <= 1'b0;
         ack_s2_r <= 1'b0;
         ack_s3_r <= 1'b0;
      end else begin
         ack_s1_r <= cmd.ack_tgl;
         ack_s2_r <= ack_s1_r;
         ack_s3_r <= ack_s2_r;
      end
   end
   assign ack_seen = ack_s2_r ^ ack_s3_r;

   // Fields stay put while busy, so the core may sample them late
   always_ff @(posedge lclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cmd.req_tgl <= 1'b0;
         cmd.wr <= 1'b0;
         cmd.page <= 1'b0;
         cmd.code <= 8'h00;
         cmd.wdata <= 16'h0000;
         lbusy_o <= 1'b0;
      end else if (lreq_i && !lbusy_o) begin
         cmd.req_tgl <= ~cmd.req_tgl;
         cmd.wr <= lwr_i;
         cmd.page <= lpage_i;
         cmd.code <= lcode_i;
         cmd.wdata <= ldata_i;
         lbusy_o <= 1'b1;
      end else if (ack_seen) begin
         lbusy_o <= 1'b0;
      end
   end

   // Answer word is stable: the core set it with the toggle
   always_ff @(posedge lclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lrsp_valid_o <= 1'b0;
         lrsp_err_o <= 1'b0;
         lrsp_data_o <= 16'h0000;
      end else begin
         lrsp_valid_o <= ack_seen;
         if (ack_seen) begin
            lrsp_err_o <= cmd.err;
            lrsp_data_o <= cmd.rdata;
         end
      end
   end
endmodule

/* File: rtl/off_seq.sv */
// Turn-off sequencer for one output: delay, then fall ramp, then off.
// Assumes en_i is already synchronised to clk_i.
`timescale 1ns/1ps
`include "off_timing_cfg.svh"
module off_seq #(
   parameter int CYC_PER_US = `NS_PER_US / `TCLK_NS
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Control
   input wire logic en_i,
   input off_timing_pkg::word_t delay_i,
   input off_timing_pkg::word_t fall_i,
   // State
   output off_timing_pkg::seq_state_e state_o
);
   import off_timing_pkg::*;
   localparam int PW = $clog2(CYC_PER_US + 1);
   seq_state_e state_r, state_nxt;
   logic [19:0] cnt_r, cnt_nxt, dly_tgt;
   logic [PW-1:0] presc_r;
   logic tick;
   logic [19:0] tgt_r;
   logic [31:0] len_r;

   assign tick = (presc_r == PW'(CYC_PER_US - 1));
   assign dly_tgt = 20'({4'h0, delay_i} * 20'd`OFF_DELAY_UNIT_US);
   assign state_o = state_r;

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      unique case (state_r)
         SEQ_OFF: if (en_i) state_nxt = SEQ_ON;
         SEQ_ON: if (!en_i) begin
            state_nxt = SEQ_DLY;
            cnt_nxt = dly_tgt;
         end
         SEQ_DLY: if (en_i) begin
            state_nxt = SEQ_ON;
         end else if (cnt_r == 20'h00000) begin
            state_nxt = SEQ_FALL;
            cnt_nxt = {4'h0, fall_i};
         end else if (tick) begin
            cnt_nxt = cnt_r - 20'h00001;
         end
         SEQ_FALL: if (cnt_r == 20'h00000) begin
            state_nxt = SEQ_OFF;
         end else if (tick) begin
            cnt_nxt = cnt_r - 20'h00001;
         end
         default: state_nxt = SEQ_OFF;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_r <= SEQ_OFF;
         cnt_r <= 20'h00000;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Restart on entry so the delay and fall counts tick in whole microseconds from entry
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) presc_r <= '0;
      else if (state_nxt != state_r || tick) presc_r <= '0;
      else presc_r <= presc_r + PW'(1);
   end

   // Checking aid: cycles spent in the present state
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         len_r <= 32'h00000000;
         tgt_r <= 20'h00000;
      end else if (state_nxt != state_r) begin
         len_r <= 32'h00000000;
         tgt_r <= cnt_nxt;
      end else begin
         len_r <= len_r + 32'h00000001;
      end
   end

   sequence s_disable;
      state_r == SEQ_ON && !en_i;
   endsequence
   property p_dly_start;
      @(posedge clk_i) disable iff (!rst_b_i)
      s_disable |=> state_r == SEQ_DLY ##0 tgt_r == $past(dly_tgt);
   endproperty
   a_dly_start: assert property (p_dly_start)
      else $error("turn-off delay not started from setting");
   property p_dly_len;
      @(posedge clk_i) disable iff (!rst_b_i)
      (state_r == SEQ_DLY && state_nxt == SEQ_FALL)
         |-> len_r == 32'(tgt_r) * 32'(CYC_PER_US);
   endproperty
   a_dly_len: assert property (p_dly_len)
      else $error("turn-off delay length wrong");
   property p_fall_len;
      @(posedge clk_i) disable iff (!rst_b_i)
      (state_r == SEQ_FALL && state_nxt == SEQ_OFF)
         |-> len_r == 32'(tgt_r) * 32'(CYC_PER_US);
   endproperty
   a_fall_len: assert property (p_fall_len)
      else $error("fall time length wrong");
endmodule

/* File: verif/host_model.sv */
// Host model on the far side of the link: one request at a time.
// Assumes the bench ceiling catches a request that is never answered.
`timescale 1ns/1ps
`include "off_timing_cfg.svh"
module host_model (
   // Link clock made here
   output logic lclk_o,
   // Request
   output logic lreq_o,
   output logic lwr_o,
   output logic lpage_o,
   output logic [7:0] lcode_o,
   output off_timing_pkg::word_t ldata_o,
   // Answer
   input wire logic lbusy_i,
   input wire logic lrsp_valid_i,
   input wire logic lrsp_err_i,
   input off_timing_pkg::word_t lrsp_data_i
);
   import off_timing_pkg::*;
   logic run = 1'b1;
   logic busy_seen = 1'b0;
   initial begin
      lclk_o = 1'b0;
      lreq_o = 1'b0;
      lwr_o = 1'b0;
      lpage_o = 1'b0;
      lcode_o = 8'h00;
      ldata_o = 16'h0000;
   end
   // Clock stands low between transfers
   always begin
      #6;
      if (run || lclk_o) begin
         lclk_o = ~lclk_o;
      end
   end
   task automatic xfer(input logic wr, input logic page,
      input logic [7:0] code, input word_t data,
      output word_t rdata, output logic err);
      run = 1'b1;
      repeat (2) @(posedge lclk_o);
      @(negedge lclk_o);
      while (lbusy_i !== 1'b0) @(negedge lclk_o);
      lreq_o = 1'b1;
      lwr_o = wr;
      lpage_o = page;
      lcode_o = code;
      ldata_o = data;
      @(negedge lclk_o);
      lreq_o = 1'b0;
      // Busy must show one edge after the take
      busy_seen = lbusy_i;
      // Answer pulse sampled where settled; a lost one runs into the
      // bench ceiling, which counts it as a mismatch
      while (lrsp_valid_i !== 1'b1) @(negedge lclk_o);
      rdata = lrsp_data_i;
      err = lrsp_err_i;
      // Released fields must not look live
      lcode_o = ~lcode_o;
      ldata_o = ~ldata_o;
      run = 1'b0;
   endtask
   task automatic commit(output logic err);
      word_t d;
      xfer(1'b1, 1'b0, `CMD_COMMIT, 16'h0000, d, err);
   endtask
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the turn-off timing and status summary block.
// Assumes the host model drives the link side.
`timescale 1ns/1ps
`include "off_timing_cfg.svh"
`define CHK_EQ(got, exp) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) begin \
         num_errors++; \
         $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
      end \
   end
module testbench;
   import off_timing_pkg::*;
   localparam int cpu = 2;
   localparam logic [24:0] bad_req [6] = '{
      {1'b1, `REG_SUM_BYTE, 16'h0000}, {1'b1, `REG_SUM_WORD, 16'h0000},
      {1'b0, 8'h00, 16'h0000}, {1'b0, `CMD_COMMIT, 16'h0000},
      {1'b1, `REG_OFF_DELAY, 16'h03E9}, {1'b1, `REG_OFF_FALL, 16'h2711}};
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [1:0] en = 2'b00;
   logic [1:0] pg = 2'b00;
   logic [13:0] pins = 14'h0000;
   logic lclk, lreq, lwr, lpage, lbusy, lrsp_valid, lrsp_err;
   logic [7:0] lcode;
   word_t ldata, lrsp_data, rd_d, ex_w;
   logic rd_e;
   logic [1:0] pwr_on, fall_act;
   int num_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   int n_dly, n_fall;
   always #12.5 clk = ~clk;
   off_timing_status #(.CYC_PER_US(cpu)) off_timing_status_inst (
      .clk_i(clk), .rst_b_i(rst_b), .lclk_i(lclk), .lreq_i(lreq),
      .lwr_i(lwr), .lpage_i(lpage), .lcode_i(lcode), .ldata_i(ldata),
      .lbusy_o(lbusy), .lrsp_valid_o(lrsp_valid), .lrsp_err_o(lrsp_err),
      .lrsp_data_o(lrsp_data), .en_i(en), .pgood_i(pg),
      .vout_ov_i(pins[1:0]), .vout_oth_i(pins[3:2]),
      .iout_oc_i(pins[5:4]), .iout_oth_i(pins[7:6]),
      .vin_uv_i(pins[8]), .vin_oth_i(pins[9]), .temp_i(pins[10]),
      .comm_mem_logic_fault_flag_i(pins[11]),
      .vendor_event_flag_i(pins[12]), .other_i(pins[13]),
      .pwr_on_o(pwr_on), .fall_act_o(fall_act));
   host_model host_model_inst (
      .lclk_o(lclk), .lreq_o(lreq), .lwr_o(lwr), .lpage_o(lpage),
      .lcode_o(lcode), .ldata_o(ldata), .lbusy_i(lbusy),
      .lrsp_valid_i(lrsp_valid), .lrsp_err_i(lrsp_err),
      .lrsp_data_i(lrsp_data));
   function automatic word_t exp_sum(logic [13:0] p, logic [1:0] e,
      logic [1:0] g);
      word_t w;
      w = 16'h0000;
      w[15] = |p[3:0];
      w[14] = |p[7:4];
      w[13] = p[8] | p[9];
      w[12] = p[12];
      w[11] = ~&g;
      w[6] = ~&e;
      w[5] = |p[1:0];
      w[4] = |p[5:4];
      w[3] = p[8];
      w[2] = p[10];
      w[1] = p[11];
      w[0] = p[13];
      return w;
   endfunction
   task automatic give_verdict();
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic acc(input logic wr, input logic p, input logic [7:0] c,
      input word_t d);
      host_model_inst.xfer(wr, p, c, d, rd_d, rd_e);
      `CHK_EQ(host_model_inst.busy_seen, 1'b1);
   endtask
   task automatic t_reset();
      for (int p = 0; p < 2; p++) begin
         acc(1'b0, p[0], `REG_OFF_DELAY, 16'h0000);
         `CHK_EQ(rd_d, `OFF_DELAY_RST);
         acc(1'b0, p[0], `REG_OFF_FALL, 16'h0000);
         `CHK_EQ(rd_d, `OFF_FALL_RST);
      end
      acc(1'b0, 1'b0, `REG_SUM_WORD, 16'h0000);
      `CHK_EQ(rd_d, exp_sum(pins, en, pg));
   endtask
   task automatic t_paged();
      acc(1'b1, 1'b0, `REG_OFF_DELAY, 16'h0003);
      `CHK_EQ(rd_e, 1'b0);
      acc(1'b1, 1'b1, `REG_OFF_DELAY, 16'h03E8);
      `CHK_EQ(rd_e, 1'b0);
      acc(1'b0, 1'b0, `REG_OFF_DELAY, 16'h0000);
      `CHK_EQ(rd_d, 16'h0003);
      acc(1'b0, 1'b1, `REG_OFF_DELAY, 16'h0000);
      `CHK_EQ(rd_d, 16'h03E8);
   endtask
   task automatic t_refuse();
      for (int i = 0; i < 6; i++) begin
         acc(bad_req[i][24], 1'b1, bad_req[i][23:16], bad_req[i][15:0]);
         `CHK_EQ(rd_e, 1'b1);
      end
      acc(1'b0, 1'b1, `REG_OFF_DELAY, 16'h0000);
      `CHK_EQ(rd_d, 16'h03E8);
      acc(1'b0, 1'b1, `REG_OFF_FALL, 16'h0000);
      `CHK_EQ(rd_d, `OFF_FALL_RST);
   endtask
   task automatic t_summary();
      @(negedge clk);
      en = 2'b11;
      pg = 2'b11;
      for (int i = 0; i <= 14; i++) begin
         @(negedge clk);
         pins = (i == 14) ? 14'h3FFF : 14'h0001 << i;
         if (i == 14) pg = 2'b01;
         repeat (6) @(negedge clk);
         ex_w = exp_sum(pins, en, pg);
         acc(1'b0, 1'b0, `REG_SUM_WORD, 16'h0000);
         `CHK_EQ(rd_d, ex_w);
         acc(1'b0, 1'b1, `REG_SUM_BYTE, 16'h0000);
         `CHK_EQ(rd_d, {8'h00, ex_w[7:0]});
      end
      @(negedge clk);
      pins = 14'h0000;
      pg = 2'b11;
      repeat (6) @(negedge clk);
   endtask
   task automatic off_ramp(output int nd, output int nf);
      @(negedge clk);
      en[0] = 1'b0;
      nd = 0;
      nf = 0;
      while (fall_act[0] !== 1'b1 && nd < 5000) begin
         @(negedge clk);
         nd++;
      end
      while (fall_act[0] === 1'b1 && nf < 5000) begin
         @(negedge clk);
         nf++;
      end
      `CHK_EQ(pwr_on, 2'b10);
      acc(1'b0, 1'b0, `REG_SUM_WORD, 16'h0000);
      `CHK_EQ(rd_d, 16'h0040);
      en[0] = 1'b1;
      repeat (4) @(negedge clk);
   endtask
   task automatic t_seq();
      acc(1'b1, 1'b0, `REG_OFF_FALL, 16'h0014);
      acc(1'b0, 1'b0, `REG_OFF_FALL, 16'h0000);
      `CHK_EQ(rd_d, 16'h0014);
      off_ramp(n_dly, n_fall);
      ex_w = 16'(3 * `OFF_DELAY_UNIT_US * cpu + 1);
      `CHK_EQ(n_dly >= ex_w && n_dly <= ex_w + 7, 1'b1);
      `CHK_EQ(n_fall, `OFF_FALL_RST * cpu + 1);
      host_model_inst.commit(rd_e);
      `CHK_EQ(rd_e, 1'b0);
      off_ramp(n_dly, n_fall);
      `CHK_EQ(n_fall, 20 * cpu + 1);
   endtask
   // Ceiling well above the few thousand cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         give_verdict();
      end
   end
   initial begin
      repeat (4) @(negedge clk);
      rst_b = 1'b1;
      t_reset();
      t_paged();
      t_refuse();
      t_summary();
      t_seq();
      give_verdict();
   end
endmodule
